// *** apdl_map.svh ***
// Purpose: offsets, field positions, reset values and prescale masks
// Assumes: byte address of a register is four times its index
// Notes: definitions only
`ifndef APDL_MAP_SVH
`define APDL_MAP_SVH

// register indices; byte address = index * 4
`define APDL_IDX_DAC_HI 6'h06
`define APDL_IDX_DAC_LO 6'h07
`define APDL_IDX_TONE_CTL 6'h08
`define APDL_IDX_TONE_FIFO 6'h09

// reset values
`define APDL_RST_DAC_HI 8'hA2
`define APDL_RST_DAC_LO 8'h00
`define APDL_RST_TONE_CTL 8'h60
`define APDL_RST_TONE_FIFO 8'h00

// field positions
`define APDL_DAC_MODE_MSB 7
`define APDL_DAC_MODE_LSB 5
`define APDL_DAC_NIB_MSB 3
`define APDL_LOCK_SEL_MSB 7
`define APDL_LOCK_SEL_LSB 6
`define APDL_LOCK_OD_BIT 5
`define APDL_TONE_MODE_MSB 2

// prescale masks for the two divided converter rates
`define APDL_PRE_DIV16 4'hF
`define APDL_PRE_DIV4 4'h3

`endif

// *** apdl_pkg.sv ***
// Purpose: types shared by the auxiliary output bank
// Assumes: nothing
// Notes: pin struct carries the two-signal form of a two-way pin, level and enable
package apdl_pkg;

    // converter pin modes, codes as stored in the mode field
    typedef enum logic [2:0] {
        APDL_MODE_LOW = 3'h0,
        APDL_MODE_HIGH = 3'h1,
        APDL_MODE_HIZ = 3'h2,
        APDL_MODE_DIV16 = 3'h4,
        APDL_MODE_DIV4 = 3'h5,
        APDL_MODE_FULL = 3'h6
    } apdl_dac_mode_t;

    // lock pin source select
    typedef enum logic [1:0] {
        APDL_LOCK_ZERO = 2'h0,
        APDL_LOCK_ONE = 2'h1,
        APDL_LOCK_CARRIER = 2'h2,
        APDL_LOCK_LOCKED = 2'h3
    } apdl_lock_sel_t;

    // output level and enable of a pin
    typedef struct packed {
        logic o;
        logic oe;
    } apdl_pin_t;

endpackage

// *** apdl_regs.sv ***
// Purpose: converter pin, lock pin and tone byte queue register bank
// Assumes: Avalon-MM slave, byte addresses, data in the low byte
// Notes: every access waits exactly one cycle before its answer
`include "apdl_map.svh"
`timescale 1ns/1ps
`default_nettype none

module apdl_regs
    import apdl_pkg::*;
#(
    parameter int DEPTH = 4
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic reset_i,
    // avalon-mm slave
    input wire logic [7:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [3:0] avs_byteenable_i,
    input wire logic [31:0] avs_writedata_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    // demodulator flags
    input wire logic carrier_found_flag_i,
    input wire logic demod_lock_flag_i,
    // pins
    output apdl_pin_t dac_pin_o,
    output apdl_pin_t lock_pin_o,
    // tone modulator side
    input wire logic tone_ready_i,
    output logic tone_valid_o,
    output logic [7:0] tone_byte_o,
    output logic [2:0] tone_mode_o,
    output logic tone_fifo_full_o,
    output logic tone_fifo_empty_o
);

    localparam int AW = $clog2(DEPTH);
    // refuse a queue depth the pointers cannot wrap on
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
        $error("apdl_regs: DEPTH must be a power of two, at least 2");
    end
    // register contents, queue storage and pointers
    logic [7:0] dac_hi, dac_lo, tone_ctl, tone_last;
    logic [7:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr, rd_ptr;
    logic [AW:0] count, next_count;
    logic [3:0] pre;
    logic [11:0] cnt, dac_val;
    logic tick, wr_ok, push, take, lock_level;
    apdl_dac_mode_t dac_mode;
    // word decode for the queue push
    function automatic logic hit(input logic [7:0] a,
                                 input logic [5:0] idx);
        hit = (a[7:2] == idx);
    endfunction
    assign dac_mode = apdl_dac_mode_t'(
        dac_hi[`APDL_DAC_MODE_MSB:`APDL_DAC_MODE_LSB]);
    assign dac_val = {dac_hi[`APDL_DAC_NIB_MSB:0], dac_lo};
    // a write lands on the cycle waitrequest is low, lane 0 only
    assign wr_ok = avs_write_i && !avs_waitrequest_o && avs_byteenable_i[0];
    // one wait state: low for one cycle after each request is seen
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            avs_waitrequest_o <= 1'b1;
        end else begin
            avs_waitrequest_o <= !((avs_read_i || avs_write_i)
                                   && avs_waitrequest_o);
        end
    end
    // read data is latched while waiting; unmapped words read zero
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            avs_readdata_o <= 32'h0000_0000;
        end else if (avs_read_i && avs_waitrequest_o) begin
            unique case (avs_address_i[7:2])
                `APDL_IDX_DAC_HI: avs_readdata_o <= {24'h00_0000, dac_hi};
                `APDL_IDX_DAC_LO: avs_readdata_o <= {24'h00_0000, dac_lo};
                `APDL_IDX_TONE_CTL: avs_readdata_o <= {24'h00_0000, tone_ctl};
                `APDL_IDX_TONE_FIFO: avs_readdata_o <= {24'h00_0000, tone_last};
                default: avs_readdata_o <= 32'h0000_0000;
            endcase
        end
    end
    // control registers; bit 4 of dac_hi and bits 4:3 of tone_ctl are
    // stored as written, software keeps them zero
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            dac_hi <= `APDL_RST_DAC_HI;
            dac_lo <= `APDL_RST_DAC_LO;
            tone_ctl <= `APDL_RST_TONE_CTL;
            tone_last <= `APDL_RST_TONE_FIFO;
        end else if (wr_ok) begin
            unique case (avs_address_i[7:2])
                `APDL_IDX_DAC_HI: dac_hi <= avs_writedata_i[7:0];
                `APDL_IDX_DAC_LO: dac_lo <= avs_writedata_i[7:0];
                `APDL_IDX_TONE_CTL: tone_ctl <= avs_writedata_i[7:0];
                `APDL_IDX_TONE_FIFO: tone_last <= avs_writedata_i[7:0];
                default: ;
            endcase
        end
    end
    // tone modulator mode bits leave as a registered copy
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            tone_mode_o <= 3'h0;
        end else begin
            tone_mode_o <= tone_ctl[`APDL_TONE_MODE_MSB:0];
        end
    end
    // byte queue: a full queue drops the byte, software checks full first
    assign push = wr_ok && hit(avs_address_i, `APDL_IDX_TONE_FIFO)
                  && (count != DEPTH[AW:0]);
    assign take = (count != '0) && (!tone_valid_o || tone_ready_i);
    always_comb begin
        next_count = count;
        if (push && !take) begin
            next_count = count + 1'b1;
        end else if (take && !push) begin
            next_count = count - 1'b1;
        end
    end
    // queue storage and pointers
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
            for (int i = 0; i < DEPTH; i++) begin
                mem[i] <= 8'h00;
            end
        end else begin
            count <= next_count;
            if (push) begin
                mem[wr_ptr] <= avs_writedata_i[7:0];
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (take) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
        end
    end
    // output stage keeps tone byte and valid straight off flops
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            tone_valid_o <= 1'b0;
            tone_byte_o <= 8'h00;
            tone_fifo_full_o <= 1'b0;
            tone_fifo_empty_o <= 1'b1;
        end else begin
            if (take) begin
                tone_valid_o <= 1'b1;
                tone_byte_o <= mem[rd_ptr];
            end else if (tone_ready_i) begin
                tone_valid_o <= 1'b0;
            end
            tone_fifo_full_o <= (next_count == DEPTH[AW:0]);
            tone_fifo_empty_o <= (next_count == '0);
        end
    end
    // rate prescaler runs free; tick picks the modulation rate
    always_comb begin
        unique case (dac_mode)
            APDL_MODE_DIV16: tick = (pre == `APDL_PRE_DIV16);
            APDL_MODE_DIV4: tick = ((pre & `APDL_PRE_DIV4)
                                    == `APDL_PRE_DIV4);
            APDL_MODE_FULL: tick = 1'b1;
            default: tick = 1'b0;
        endcase
    end
    // duty counter; advancing only on tick stretches each step
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            pre <= 4'h0;
            cnt <= 12'h000;
        end else begin
            pre <= pre + 4'h1;
            if (tick) begin
                cnt <= cnt + 12'h001;
            end
        end
    end
    // converter pin; reserved codes release the pin as the safe choice
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            dac_pin_o <= '{o: 1'b0, oe: 1'b0};
        end else begin
            unique case (dac_mode)
                APDL_MODE_LOW: dac_pin_o <= '{o: 1'b0, oe: 1'b1};
                APDL_MODE_HIGH: dac_pin_o <= '{o: 1'b1, oe: 1'b1};
                APDL_MODE_HIZ: dac_pin_o <= '{o: 1'b0, oe: 1'b0};
                APDL_MODE_DIV16, APDL_MODE_DIV4, APDL_MODE_FULL: begin
                    dac_pin_o <= '{o: (dac_val > cnt), oe: 1'b1};
                end
                default: dac_pin_o <= '{o: 1'b0, oe: 1'b0};
            endcase
        end
    end
    // lock pin source select
    always_comb begin
        unique case (apdl_lock_sel_t'(
            tone_ctl[`APDL_LOCK_SEL_MSB:`APDL_LOCK_SEL_LSB]))
            APDL_LOCK_ZERO: lock_level = 1'b0;
            APDL_LOCK_ONE: lock_level = 1'b1;
            APDL_LOCK_CARRIER: lock_level = carrier_found_flag_i;
            APDL_LOCK_LOCKED: lock_level = demod_lock_flag_i;
        endcase
    end
    // open drain only pulls low and lets the pull-up make the high
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            lock_pin_o <= '{o: 1'b0, oe: 1'b0};
        end else if (tone_ctl[`APDL_LOCK_OD_BIT]) begin
            lock_pin_o <= '{o: 1'b0, oe: !lock_level};
        end else begin
            lock_pin_o <= '{o: lock_level, oe: 1'b1};
        end
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (reset_i);
    sequence s_full_run;
        (dac_mode == APDL_MODE_FULL) [*2];
    endsequence
    property p_mode_low;
        (dac_mode == APDL_MODE_LOW) |=> dac_pin_o.oe && !dac_pin_o.o;
    endproperty
    a_mode_low: assert property (p_mode_low)
        else $error("converter pin not driven low");
    property p_mode_high;
        (dac_mode == APDL_MODE_HIGH) |=> dac_pin_o.oe && dac_pin_o.o;
    endproperty
    a_mode_high: assert property (p_mode_high)
        else $error("converter pin not driven high");
    property p_mode_hiz;
        (dac_mode == APDL_MODE_HIZ) |=> !dac_pin_o.oe;
    endproperty
    a_mode_hiz: assert property (p_mode_hiz)
        else $error("converter pin driven in release mode");
    property p_div16_hold;
        (dac_mode == APDL_MODE_DIV16 && pre != 4'hF) |=> $stable(cnt);
    endproperty
    a_div16_hold: assert property (p_div16_hold)
        else $error("duty counter moved between sixteenth ticks");
    property p_full_step;
        s_full_run |-> cnt == 12'($past(cnt) + 12'h001);
    endproperty
    a_full_step: assert property (p_full_step)
        else $error("duty counter not stepping every clock");
    property p_duty;
        (dac_mode == APDL_MODE_FULL && dac_val > cnt) |=> dac_pin_o.o;
    endproperty
    a_duty: assert property (p_duty)
        else $error("converter pin low below its value");
    property p_lock_carrier;
        (tone_ctl[7:5] == 3'h4) |=>
            lock_pin_o.oe && lock_pin_o.o == $past(carrier_found_flag_i);
    endproperty
    a_lock_carrier: assert property (p_lock_carrier)
        else $error("lock pin does not follow carrier found");
    property p_open_drain;
        (tone_ctl[7:5] == 3'h3) |=> !lock_pin_o.oe;
    endproperty
    a_open_drain: assert property (p_open_drain)
        else $error("open drain lock pin drives a high");
    property p_push;
        (push && !take) |=> count == $past(count) + 1'b1;
    endproperty
    a_push: assert property (p_push)
        else $error("queue write did not add a byte");
    property p_answer;
        ((avs_read_i || avs_write_i) && avs_waitrequest_o)
            |=> !avs_waitrequest_o ##1 avs_waitrequest_o;
    endproperty
    a_answer: assert property (p_answer)
        else $error("bus answer not one cycle after request");
endmodule

`default_nettype wire

// *** apdl_filter_model.sv ***
// Purpose: low-pass stand-in that integrates the converter pin
// Assumes: no pull resistor on the node, so a released pin adds no charge
// Notes: one measurement at a time, started by a one-cycle pulse
`timescale 1ns/1ps
`default_nettype none

module apdl_filter_model
    import apdl_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic reset_i,
    // converter pin
    input wire apdl_pin_t pin_i,
    // measurement control
    input wire logic start_i,
    input wire logic [16:0] window_i,
    output logic [16:0] high_count_o,
    output logic done_o
);
    logic [16:0] left;

    // charge over a window; a full period gives an exact count
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            left <= 17'h0;
            high_count_o <= 17'h0;
            done_o <= 1'b0;
        end else if (start_i) begin
            left <= window_i;
            high_count_o <= 17'h0;
            done_o <= 1'b0;
        end else if (left != 17'h0) begin
            left <= left - 17'h1;
            high_count_o <= high_count_o + 17'(pin_i.oe & pin_i.o);
            done_o <= (left == 17'h1);
        end
    end
endmodule
`default_nettype wire

// *** aux_pwm_dac_and_lock_out_tb_top.sv ***
// Purpose: self-checking bench for the auxiliary output bank
// Assumes: one-cycle answer on the register bus, queue depth of 4
// Notes: duty windows are one full counter period per mode
`timescale 1ns/1ps
`default_nettype none

module aux_pwm_dac_and_lock_out_tb_top
    import apdl_pkg::*;
;
    logic clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic [7:0] adr = 8'h00;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [3:0] be = 4'hF;
    logic [31:0] wd = 32'h0;
    logic [31:0] rdata;
    logic waitreq;
    logic cf = 1'b0;
    logic lk = 1'b0;
    logic ready = 1'b0;
    apdl_pin_t dac_pin;
    apdl_pin_t lock_pin;
    logic tvalid, full, empty, start = 1'b0, done;
    logic [7:0] tbyte;
    logic [2:0] tmode;
    logic [16:0] win = 17'h0;
    logic [16:0] hc;
    int fail_count = 0;
    int checks_done = 0;

    // the clock keeps running through every wait
    always #5 clk_i = ~clk_i;

    apdl_regs #(.DEPTH(4)) i_dut (
        .clk_i(clk_i), .reset_i(reset_i), .avs_address_i(adr),
        .avs_read_i(rd), .avs_write_i(wr), .avs_byteenable_i(be),
        .avs_writedata_i(wd), .avs_readdata_o(rdata),
        .avs_waitrequest_o(waitreq), .carrier_found_flag_i(cf),
        .demod_lock_flag_i(lk), .dac_pin_o(dac_pin), .lock_pin_o(lock_pin),
        .tone_ready_i(ready), .tone_valid_o(tvalid), .tone_byte_o(tbyte),
        .tone_mode_o(tmode), .tone_fifo_full_o(full),
        .tone_fifo_empty_o(empty));

    apdl_filter_model i_filter (
        .clk_i(clk_i), .reset_i(reset_i), .pin_i(dac_pin), .start_i(start),
        .window_i(win), .high_count_o(hc), .done_o(done));

    task automatic end_of_test();
        if (fail_count == 0 && checks_done > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic cmp_val(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t: %h not %h", $time, got, exp);
        end
    endtask

    task automatic cmp_pin(input apdl_pin_t got, input apdl_pin_t exp);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t: pin %b not %b", $time, got, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
    endtask

    // request held until waitrequest is sampled low, then released
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [7:0] d, output logic [31:0] q);
        int n;
        @(posedge clk_i);
        adr <= a;
        wd <= {24'h0, d};
        wr <= w;
        rd <= !w;
        for (n = 0; n < 50; n++) begin
            @(posedge clk_i);
            if (waitreq === 1'b0) break;
        end
        q = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
        if (n == 50) begin
            fail_count++;
            end_of_test();
        end
    endtask

    // lock pin level from select, drive type and the two flags
    function automatic apdl_pin_t exp_lock(input logic [7:0] c,
                                           input logic f, input logic l);
        logic s;
        s = (c[7:6] == 2'h0) ? 1'b0 : (c[7:6] == 2'h1) ? 1'b1 : c[6] ? l : f;
        return c[5] ? apdl_pin_t'{o: 1'b0, oe: !s}
                    : apdl_pin_t'{o: s, oe: 1'b1};
    endfunction

    // high cycles over one period: value times the prescale
    function automatic logic [16:0] exp_duty(input int m,
                                             input logic [11:0] v);
        return 17'(v) << (2 * (6 - m));
    endfunction

    initial begin
        logic [31:0] q;
        logic [7:0] b;
        logic [11:0] v;
        logic [7:0] rst_tab [5];
        logic [7:0] sent [$];
        int k;
        int n;
        rst_tab = '{8'hA2, 8'h00, 8'h60, 8'h00, 8'h00};
        void'($urandom(80624));
        tick(4);
        reset_i <= 1'b0;
        // reset values, then one unmapped word
        for (k = 0; k < 5; k++) begin
            bus(1'b0, 8'h18 + 8'(4 * k), 8'h00, q);
            cmp_val(q, 32'(rst_tab[k]));
        end
        // a write with the low lane disabled must leave the byte alone
        be <= 4'h0;
        bus(1'b1, 8'h1C, 8'h5A, q);
        be <= 4'hF;
        bus(1'b0, 8'h1C, 8'h00, q);
        cmp_val(q, 32'h0);
        // fixed levels, release and the reserved codes
        for (k = 0; k < 8; k++) begin
            if (k >= 4 && k <= 6) continue;
            bus(1'b1, 8'h18, {3'(k), 1'b0, 4'h0}, q);
            tick(3);
            cmp_val(32'(dac_pin.oe), 32'(k < 2));
            if (k < 2) cmp_val(32'(dac_pin.o), 32'(k));
        end
        // converter modes, duty measured over one full counter period
        for (k = 4; k < 7; k++) begin
            v = (k == 6) ? 12'hFFF : 12'($urandom);
            bus(1'b1, 8'h18, {3'(k), 1'b0, v[11:8]}, q);
            bus(1'b1, 8'h1C, v[7:0], q);
            tick(2);
            win <= 17'h1000 << (2 * (6 - k));
            start <= 1'b1;
            tick(1);
            start <= 1'b0;
            tick(1);
            for (n = 0; n < 70000 && done !== 1'b1; n++) @(posedge clk_i);
            if (n == 70000) begin
                fail_count++;
                end_of_test();
            end
            cmp_val(32'(hc), 32'(exp_duty(k, v)));
        end
        // every lock source with both drive types and random flags
        for (k = 0; k < 8; k++) begin
            cf <= 1'($urandom);
            lk <= 1'($urandom);
            b = {k[2:0], 2'b00, 3'($urandom)};
            bus(1'b1, 8'h20, b, q);
            tick(3);
            cmp_pin(lock_pin, exp_lock(b, cf, lk));
            cmp_val(32'(tmode), 32'(b[2:0]));
        end
        // overfill the queue while stalled, then drain in order
        for (k = 0; k < 7; k++) begin
            b = 8'($urandom);
            if (k < 5) sent.push_back(b);
            bus(1'b1, 8'h24, b, q);
        end
        cmp_val(32'(full), 32'h1);
        ready <= 1'b1;
        for (n = 0; n < 40; n++) begin
            @(posedge clk_i);
            if (tvalid === 1'b1) begin
                b = (sent.size() > 0) ? sent.pop_front() : 8'hEE;
                cmp_val(32'(tbyte), 32'(b));
            end
        end
        cmp_val(32'(sent.size()), 32'h0);
        cmp_val(32'({empty, tvalid}), 32'h2);
        end_of_test();
    end
endmodule
`default_nettype wire
